//--- rtl/fth_consts.vh
// Constants for the flash command host: command bytes, status bits,
// register offsets, control fields, sequencer kinds and bus timing.
// Assumes inclusion by bare name from the rtl folder.
`ifndef FTH_CONSTS_VH
`define FTH_CONSTS_VH

// ==========================================
// Flash command bytes and protect confirm address
`define FTH_CMD_READ_ARRAY 8'hFF
`define FTH_CMD_TWO_BYTE 8'hFB
`define FTH_CMD_ERASE_ALL 8'hA7
`define FTH_CMD_CONFIRM 8'hD0
`define FTH_CMD_RESET_WP 8'h47
`define FTH_CMD_SET_WP 8'h57
`define FTH_WP_CONFIRM_ADDR 18'h0_00FF

// ==========================================
// Compatible status byte bit positions
`define FTH_STAT_READY 7
`define FTH_STAT_ERR_HI 5
`define FTH_STAT_ERR_LO 4
`define FTH_STAT_VPP 3

// ==========================================
// Register byte offsets
`define FTH_OFF_CTRL 5'h00
`define FTH_OFF_ADDR 5'h04
`define FTH_OFF_DATA 5'h08
`define FTH_OFF_STATUS 5'h0C
`define FTH_OFF_RDATA 5'h10

// ==========================================
// Control register fields and reset values
`define FTH_CTRL_OP_HI 3
`define FTH_CTRL_CHECK 4
`define FTH_CTRL_SETWP 5
`define FTH_CTRL_PWRLOST 6
`define FTH_OP_NONE 4'h0
`define FTH_OP_TWO_BYTE 4'h1
`define FTH_OP_ERASE_ALL 4'h2
`define FTH_OP_CLEAR 4'h3
`define FTH_OP_READ 4'h4
`define FTH_OP_RECOVER 4'h5
`define FTH_OP_FINISH 4'h6
`define FTH_OP_CHECK 4'h7
`define FTH_RST_ADDR 18'h0_0000
`define FTH_RST_DATA 16'h0000

// ==========================================
// Sequencer step kinds
`define FTH_K_WRITE 3'h0
`define FTH_K_POLL 3'h1
`define FTH_K_READ 3'h2
`define FTH_K_SKIP 3'h3
`define FTH_K_END 3'h4

// ==========================================
// Flash bus timing in sys_clk cycles
`define FTH_SETUP_CYC 2
`define FTH_STROBE_CYC 4
`define FTH_SYNC_CYC 2

`endif

//--- rtl/fth_flash_cycle.v
// One asynchronous flash bus cycle: write (latched at the rising edge of
// the write strobe) or read (chip and output enable low, data sampled).
// Assumes the flash data pins return through flashDqIn from outside.
`timescale 1ns/1ps
`include "fth_consts.vh"
module fth_flash_cycle #(
  parameter SETUP_CYC = `FTH_SETUP_CYC,
  parameter STROBE_CYC = `FTH_STROBE_CYC
) (
  input wire sys_clk,
  input wire reset_n,
  input wire clkEn,
  input wire start,
  input wire isWrite,
  input wire [17:0] addr,
  input wire [7:0] wdata,
  output reg done,
  output reg [7:0] rdata,
  output reg flashCeN,
  output reg flashOeN,
  output reg flashWeN,
  output reg [17:0] flashAddr,
  output reg [7:0] flashDqOut,
  output reg flashDqOe,
  input wire [7:0] flashDqIn
);
  localparam P_IDLE = 4'b0001;
  localparam P_SETUP = 4'b0010;
  localparam P_STROBE = 4'b0100;
  localparam P_HOLD = 4'b1000;
  localparam integer READ_CYC = STROBE_CYC + `FTH_SYNC_CYC;
  reg [3:0] phase;
  reg [7:0] cnt;
  reg writing;
  reg [7:0] dqMeta;
  reg [7:0] dqSync;

  // ==========================================
  // Data pin synchroniser
  always @(posedge sys_clk)
    if (clkEn)
    begin
      dqMeta <= flashDqIn;
      dqSync <= dqMeta;
    end

  // ==========================================
  // Cycle sequencer
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      phase <= P_IDLE;
      cnt <= 8'h00;
      writing <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      flashCeN <= 1'b1;
      flashOeN <= 1'b1;
      flashWeN <= 1'b1;
      flashAddr <= 18'h0_0000;
      flashDqOut <= 8'h00;
      flashDqOe <= 1'b0;
    end
    else if (clkEn)
    begin
      done <= 1'b0;
      case (phase)
        P_IDLE:
          if (start)
          begin
            phase <= P_SETUP;
            cnt <= SETUP_CYC[7:0];
            writing <= isWrite;
            flashAddr <= addr;
            flashDqOut <= wdata;
            flashDqOe <= isWrite;
            flashCeN <= 1'b0;
          end
        P_SETUP:
          if (cnt <= 8'h01)
          begin
            phase <= P_STROBE;
            cnt <= writing ? STROBE_CYC[7:0] : READ_CYC[7:0];
            flashWeN <= ~writing;
            flashOeN <= writing;
          end
          else
            cnt <= cnt - 8'h01;
        P_STROBE:
          if (cnt <= 8'h01)
          begin
            // Raising the strobes latches the write and ends the status refresh
            phase <= P_HOLD;
            flashWeN <= 1'b1;
            flashOeN <= 1'b1;
            if (!writing)
              rdata <= dqSync;
          end
          else
            cnt <= cnt - 8'h01;
        P_HOLD:
        begin
          phase <= P_IDLE;
          flashCeN <= 1'b1;
          flashDqOe <= 1'b0;
          done <= 1'b1;
        end
        default:
          phase <= P_IDLE;
      endcase
    end
  end
endmodule // fth_flash_cycle

//--- rtl/fth_host_ctrl.v
// Host controller for a byte-wide flash with a command interface:
// two-byte writes, erase of all unlocked blocks, status check and recovery.
// Software reaches it over Avalon-MM with waitrequest; flash pins go out.
// Function
// RULE1 - Both error bits: sequence error, clear first
// RULE2 - Write FFH to return to read array
// RULE3 - Two-byte write starts with FBH command
// RULE4 - First data byte chosen by address bit 0
// RULE5 - Second write loads the other byte
// RULE6 - Toggle enables to refresh status; bit7 ready
// RULE7 - Erase all: A7H then D0H confirm
// RULE8 - Full check after each or after series
// RULE9 - Low program voltage: clear bits 3-5 first
// RULE10 - After power loss: clear, unprotect, retry, protect
// RULE11 - Voltage flag set: clear, unprotect, retry, protect
// RULE12 - Voltage flag clear: clear, retry erase
// RULE13 - All blocks locked after power-up or reset
// RULE14 - Bit7 low while operation runs
`timescale 1ns/1ps
`include "fth_consts.vh"
module fth_host_ctrl #(
  parameter SETUP_CYC = `FTH_SETUP_CYC,
  parameter STROBE_CYC = `FTH_STROBE_CYC,
  parameter [7:0] CLEAR_CMD = 8'h50
) (
  input wire sys_clk,
  input wire reset_n,
  input wire clkEn,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire flashCeN,
  output wire flashOeN,
  output wire flashWeN,
  output wire [17:0] flashAddr,
  output wire [7:0] flashDqOut,
  output wire flashDqOe,
  input wire [7:0] flashDqIn
);
  localparam S_IDLE = 4'b0001;
  localparam S_STEP = 4'b0010;
  localparam S_BUS = 4'b0100;
  localparam S_EVAL = 4'b1000;

  reg [3:0] state;
  reg [3:0] op;
  reg [3:0] step;
  reg checkEach;
  reg setWp;
  reg powerLost;
  reg wpPath;
  reg [17:0] targetAddr;
  reg [15:0] writeData;
  reg [7:0] lastStatus;
  reg [7:0] arrayByte;
  reg seqErr;
  reg opErr;
  reg vppLow;
  reg refused;
  reg arrayMode;
  reg ack;
  reg cycStart;
  reg cycWrite;
  reg [17:0] cycAddr;
  reg [7:0] cycData;
  reg [2:0] kind;
  wire cycDone;
  wire [7:0] cycRdata;
  wire [28:0] micro;
  wire busy;
  wire errAny;
  wire accept;
  wire [4:0] byteOff;
  wire [3:0] newOp;

  // ==========================================
  // Register offset match
  function hit;
    input [4:0] off;
    input [4:0] regOff;
    begin
      hit = (off == regOff);
    end
  endfunction

  // ==========================================
  // Micro-program: {kind, address, data} for each op and step
  function [28:0] stepOf;
    input [3:0] fop;
    input [3:0] fstep;
    input fwp;
    input fset;
    input farray;
    input [17:0] fadr;
    input [15:0] fdat;
    reg [2:0] wpKind;
    reg [2:0] setKind;
    begin
      wpKind = fwp ? `FTH_K_WRITE : `FTH_K_SKIP;
      setKind = (fwp && fset) ? `FTH_K_WRITE : `FTH_K_SKIP;
      case ({fop, fstep})
        {`FTH_OP_TWO_BYTE, 4'h0}: stepOf = {`FTH_K_WRITE, 18'h0_0000, `FTH_CMD_TWO_BYTE}; // [RULE3]
        {`FTH_OP_TWO_BYTE, 4'h1}: stepOf = {`FTH_K_WRITE, fadr, fadr[0] ? fdat[15:8] : fdat[7:0]}; // [RULE4]
        {`FTH_OP_TWO_BYTE, 4'h2}: stepOf = {`FTH_K_WRITE, fadr, fadr[0] ? fdat[7:0] : fdat[15:8]}; // [RULE5]
        {`FTH_OP_TWO_BYTE, 4'h3}: stepOf = {`FTH_K_POLL, 18'h0_0000, 8'h00};
        {`FTH_OP_ERASE_ALL, 4'h0}: stepOf = {`FTH_K_WRITE, 18'h0_0000, `FTH_CMD_ERASE_ALL}; // [RULE7]
        {`FTH_OP_ERASE_ALL, 4'h1}: stepOf = {`FTH_K_WRITE, 18'h0_0000, `FTH_CMD_CONFIRM}; // [RULE7]
        {`FTH_OP_ERASE_ALL, 4'h2}: stepOf = {`FTH_K_POLL, 18'h0_0000, 8'h00};
        {`FTH_OP_CLEAR, 4'h0}: stepOf = {`FTH_K_WRITE, 18'h0_0000, CLEAR_CMD}; // [RULE9]
        {`FTH_OP_READ, 4'h0}: stepOf = {farray ? `FTH_K_SKIP : `FTH_K_WRITE, 18'h0_0000, `FTH_CMD_READ_ARRAY}; // [RULE2]
        {`FTH_OP_READ, 4'h1}: stepOf = {`FTH_K_READ, fadr, 8'h00};
        {`FTH_OP_FINISH, 4'h0}: stepOf = {`FTH_K_WRITE, 18'h0_0000, `FTH_CMD_READ_ARRAY}; // [RULE2]
        {`FTH_OP_CHECK, 4'h0}: stepOf = {`FTH_K_POLL, 18'h0_0000, 8'h00}; // [RULE8]
        {`FTH_OP_RECOVER, 4'h0}: stepOf = {`FTH_K_WRITE, 18'h0_0000, CLEAR_CMD}; // [RULE10] [RULE11] [RULE12]
        // Blocks come up locked, so with wpPath set protection is lifted after the clear, before the retry
        {`FTH_OP_RECOVER, 4'h1}: stepOf = {wpKind, 18'h0_0000, `FTH_CMD_RESET_WP}; // [RULE11] [RULE13]
        {`FTH_OP_RECOVER, 4'h2}: stepOf = {wpKind, `FTH_WP_CONFIRM_ADDR, `FTH_CMD_CONFIRM}; // [RULE10]
        {`FTH_OP_RECOVER, 4'h3}: stepOf = {fwp ? `FTH_K_POLL : `FTH_K_SKIP, 18'h0_0000, 8'h00};
        {`FTH_OP_RECOVER, 4'h4}: stepOf = {`FTH_K_WRITE, 18'h0_0000, `FTH_CMD_ERASE_ALL}; // [RULE12]
        {`FTH_OP_RECOVER, 4'h5}: stepOf = {`FTH_K_WRITE, 18'h0_0000, `FTH_CMD_CONFIRM};
        {`FTH_OP_RECOVER, 4'h6}: stepOf = {`FTH_K_POLL, 18'h0_0000, 8'h00};
        {`FTH_OP_RECOVER, 4'h7}: stepOf = {setKind, 18'h0_0000, `FTH_CMD_SET_WP}; // [RULE10]
        {`FTH_OP_RECOVER, 4'h8}: stepOf = {setKind, `FTH_WP_CONFIRM_ADDR, `FTH_CMD_CONFIRM}; // [RULE11]
        default:
          stepOf = {`FTH_K_END, 18'h0_0000, 8'h00};
      endcase
    end
  endfunction

  assign micro = stepOf(op, step, wpPath, setWp, arrayMode, targetAddr, writeData);
  assign busy = (state != S_IDLE);
  assign errAny = seqErr | opErr | vppLow;
  assign byteOff = {avs_address, 2'b00};
  assign newOp = avs_writedata[`FTH_CTRL_OP_HI:0];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  // A new write or erase is refused while any error flag stands
  assign accept = !busy && newOp != `FTH_OP_NONE &&
    !(errAny && (newOp == `FTH_OP_TWO_BYTE || newOp == `FTH_OP_ERASE_ALL)); // [RULE1] [RULE9]

  // ==========================================
  // Avalon-MM slave: one wait cycle, then answer
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      ack <= (avs_read | avs_write) & ~ack;
      if (avs_read && !ack)
      begin
        avs_readdata <= 32'h0000_0000;
        if (hit(byteOff, `FTH_OFF_CTRL))
          avs_readdata <= {25'h000_0000, powerLost, setWp, checkEach, op};
        else if (hit(byteOff, `FTH_OFF_ADDR))
          avs_readdata <= {14'h0000, targetAddr};
        else if (hit(byteOff, `FTH_OFF_DATA))
          avs_readdata <= {16'h0000, writeData};
        else if (hit(byteOff, `FTH_OFF_STATUS))
          avs_readdata <= {16'h0000, lastStatus, 2'b00, arrayMode, vppLow, opErr, seqErr, refused, busy};
        else if (hit(byteOff, `FTH_OFF_RDATA))
          avs_readdata <= {24'h00_0000, arrayByte};
      end
    end
  end

  // ==========================================
  // Operation sequencer
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state <= S_IDLE;
      op <= `FTH_OP_NONE;
      step <= 4'h0;
      checkEach <= 1'b0;
      setWp <= 1'b0;
      powerLost <= 1'b0;
      wpPath <= 1'b0;
      targetAddr <= `FTH_RST_ADDR;
      writeData <= `FTH_RST_DATA;
      lastStatus <= 8'h00;
      arrayByte <= 8'h00;
      seqErr <= 1'b0;
      opErr <= 1'b0;
      vppLow <= 1'b0;
      refused <= 1'b0;
      arrayMode <= 1'b1;
      cycStart <= 1'b0;
      cycWrite <= 1'b0;
      cycAddr <= 18'h0_0000;
      cycData <= 8'h00;
      kind <= `FTH_K_END;
    end
    else if (clkEn)
    begin
      cycStart <= 1'b0;
      if (avs_write && ack)
      begin
        if (hit(byteOff, `FTH_OFF_ADDR) && !busy)
          targetAddr <= avs_writedata[17:0];
        if (hit(byteOff, `FTH_OFF_DATA) && !busy)
          writeData <= avs_writedata[15:0];
        if (hit(byteOff, `FTH_OFF_CTRL))
        begin
          if (accept)
          begin
            op <= newOp;
            checkEach <= avs_writedata[`FTH_CTRL_CHECK];
            setWp <= avs_writedata[`FTH_CTRL_SETWP];
            powerLost <= avs_writedata[`FTH_CTRL_PWRLOST];
            wpPath <= vppLow | avs_writedata[`FTH_CTRL_PWRLOST]; // [RULE10] [RULE11]
            step <= 4'h0;
            refused <= 1'b0;
            state <= S_STEP;
          end
          else
            refused <= 1'b1; // [RULE1]
        end
      end
      case (state)
        S_IDLE:
          kind <= `FTH_K_END;
        S_STEP:
        begin
          kind <= micro[28:26];
          if (micro[28:26] == `FTH_K_END)
          begin
            state <= S_IDLE;
            op <= `FTH_OP_NONE;
          end
          else if (micro[28:26] == `FTH_K_SKIP)
            step <= step + 4'h1;
          else
          begin
            cycStart <= 1'b1;
            cycWrite <= (micro[28:26] == `FTH_K_WRITE);
            cycAddr <= micro[25:8];
            cycData <= micro[7:0];
            state <= S_BUS;
            if (micro[28:26] == `FTH_K_WRITE)
              arrayMode <= (micro[7:0] == `FTH_CMD_READ_ARRAY); // [RULE2]
            if (micro[28:26] == `FTH_K_WRITE && micro[7:0] == CLEAR_CMD)
            begin
              seqErr <= 1'b0; // [RULE9]
              opErr <= 1'b0;
              vppLow <= 1'b0;
            end
          end
        end
        S_BUS:
          if (cycDone)
            state <= (kind == `FTH_K_POLL) ? S_EVAL : S_STEP;
          else if (!cycStart)
            step <= step;
        S_EVAL:
        begin
          // Each poll is a fresh enable cycle so the status byte refreshes
          if (cycRdata[`FTH_STAT_READY])
          begin
            lastStatus <= cycRdata; // [RULE14]
            if (checkEach || op == `FTH_OP_CHECK)
            begin
              seqErr <= seqErr | (cycRdata[`FTH_STAT_ERR_HI] & cycRdata[`FTH_STAT_ERR_LO]); // [RULE1]
              opErr <= opErr | cycRdata[`FTH_STAT_ERR_HI] | cycRdata[`FTH_STAT_ERR_LO]; // [RULE8]
              vppLow <= vppLow | cycRdata[`FTH_STAT_VPP]; // [RULE9]
            end
            step <= step + 4'h1;
            state <= S_STEP;
          end
          else
          begin
            cycStart <= 1'b1; // [RULE6]
            state <= S_BUS;
          end
        end
        default:
          state <= S_IDLE;
      endcase
      if (state == S_BUS && cycDone && kind != `FTH_K_POLL)
      begin
        step <= step + 4'h1;
        if (kind == `FTH_K_READ)
          arrayByte <= cycRdata;
      end
    end
  end

  // ==========================================
  // Flash bus cycle engine
  fth_flash_cycle #(
    .SETUP_CYC(SETUP_CYC),
    .STROBE_CYC(STROBE_CYC)
  ) u_cycle (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .start(cycStart),
    .isWrite(cycWrite),
    .addr(cycAddr),
    .wdata(cycData),
    .done(cycDone),
    .rdata(cycRdata),
    .flashCeN(flashCeN),
    .flashOeN(flashOeN),
    .flashWeN(flashWeN),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn)
  );
endmodule // fth_host_ctrl

//--- testbench/fth_flash_model.sv
// Behavioural flash: command interface, status byte, block lock, two-byte data register.
// Assumes the bench merges this output with the controller's drive on the data wire.
`timescale 1ns/1ps
module fth_flash_model #(
  parameter BUSY_READS = 3,
  parameter [7:0] CLEAR_CMD = 8'h50
) (
  input wire ceN,
  input wire oeN,
  input wire weN,
  input wire [17:0] addr,
  input wire [7:0] dqIn,
  input wire vppLow,
  output wire [7:0] dqOut
);
  logic [7:0] mem [0:262143];
  logic [7:0] stat = 8'h00;
  logic [7:0] q = 8'h00;
  logic [15:0] dataReg = 16'h0000;
  logic [7:0] pend = 8'h00;
  logic statMode = 1'b0;
  logic unlocked = 1'b0;
  int busy = 0;
  wire sel = !ceN && !oeN;
  // Released bus shows the inverse of the last byte
  assign dqOut = sel ? q : ~q;
  // Array starts erased
  initial
    for (int i = 0; i < 262144; i++) mem[i] = 8'hFF;
  // Output value only refreshed on an enable toggle
  always @(posedge sel)
  begin
    if (busy > 0)
      busy--;
    if (statMode)
      q = {busy == 0, stat[6:0]};
    else
      q = mem[addr];
  end
  always @(posedge weN)
  begin
    if (ceN === 1'b0)
    begin
      if (pend == 8'hFB)
      begin
        dataReg[{addr[0], 3'b000} +: 8] = dqIn;
        pend = 8'h01;
      end
      else if (pend == 8'h01)
      begin
        dataReg[{~addr[0], 3'b000} +: 8] = dqIn;
        if (unlocked)
        begin
          mem[{addr[17:1], 1'b0}] = dataReg[7:0];
          mem[{addr[17:1], 1'b1}] = dataReg[15:8];
        end
        else
          stat[5:4] = 2'b11;
        busy = BUSY_READS;
        pend = 8'h00;
      end
      else if (pend == 8'hA7 || pend == 8'h47 || pend == 8'h57)
      begin
        if (dqIn != 8'hD0)
          stat[5:4] = 2'b11;
        else if (pend == 8'hA7 && vppLow)
          stat = stat | 8'h28;
        else if (pend == 8'hA7)
          for (int i = 0; i < 262144; i++) mem[i] = 8'hFF;
        else
          unlocked = (pend == 8'h47);
        busy = BUSY_READS;
        pend = 8'h00;
      end
      else
      begin
        statMode = (dqIn != 8'hFF);
        if (dqIn == CLEAR_CMD)
          stat[5:3] = 3'b000;
        if (dqIn == 8'hFB || dqIn == 8'hA7 || dqIn == 8'h47 || dqIn == 8'h57)
          pend = dqIn;
      end
    end
  end
endmodule // fth_flash_model

//--- testbench/fth_host_ctrl_properties.sv
// Concurrent checks on the flash host controller's Avalon and flash pins.
// Assumes clkEn is held high, so every sys_clk edge advances the design.
`timescale 1ns/1ps
module fth_host_ctrl_properties #(
  parameter SETUP_CYC = 2,
  parameter STROBE_CYC = 4
) (
  input wire sys_clk,
  input wire reset_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire flashCeN,
  input wire flashOeN,
  input wire flashWeN,
  input wire [17:0] flashAddr,
  input wire [7:0] flashDqOut,
  input wire flashDqOe
);
  logic [7:0] lowCnt;
  // Cycles spent with a strobe low
  always @(posedge sys_clk)
  begin
    if (!reset_n || (flashWeN && flashOeN))
      lowCnt <= 8'h00;
    else
      lowCnt <= lowCnt + 8'h01;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Assertions
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request answered without a wait state");
  a_strobe_width: assert property ($rose(flashWeN) |-> lowCnt == STROBE_CYC)
    else $error("write strobe width wrong");
  a_read_width: assert property ($rose(flashOeN) |-> lowCnt == STROBE_CYC + 2)
    else $error("read strobe width wrong");
  a_we_setup: assert property ($fell(flashWeN) |-> $past(flashCeN, SETUP_CYC) == 1'b0)
    else $error("write strobe setup too short");
  a_ce_release: assert property ($rose(flashWeN) |=> $rose(flashCeN) && !flashDqOe)
    else $error("chip enable not released after write");
  a_we_framed: assert property (!flashWeN |-> !flashCeN && flashOeN && flashDqOe)
    else $error("write strobe outside a driven cycle");
  a_read_float: assert property (!flashOeN |-> !flashCeN && !flashDqOe)
    else $error("data driven during a read");
  a_addr_hold: assert property (!flashCeN && $past(flashCeN) == 1'b0 |-> $stable(flashAddr))
    else $error("address moved within a cycle");
  a_data_hold: assert property (!flashWeN |=> flashWeN || $stable(flashDqOut))
    else $error("data moved under write strobe");
endmodule // fth_host_ctrl_properties

bind fth_host_ctrl fth_host_ctrl_properties #(.SETUP_CYC(SETUP_CYC), .STROBE_CYC(STROBE_CYC)) u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
  .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe));

//--- testbench/fth_host_ctrl_tb.sv
// Self-checking bench: register accesses over Avalon-MM drive the controller.
// Assumes the flash model stands on the pins and the checker is bound in.
`timescale 1ns/1ps
`include "fth_consts.vh"
`define FTH_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module fth_host_ctrl_tb;
  localparam [2:0] A_CTRL = 3'h0;
  localparam [2:0] A_ADDR = 3'h1;
  localparam [2:0] A_DATA = 3'h2;
  localparam [2:0] A_STAT = 3'h3;
  localparam [2:0] A_RDAT = 3'h4;
  logic sys_clk, reset_n, clkEn, avs_read, avs_write, vppLow;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, r;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, flashCeN, flashOeN, flashWeN, flashDqOe;
  wire [17:0] flashAddr;
  wire [7:0] flashDqOut, devQ;
  wire [7:0] flashDqIn = flashDqOe ? flashDqOut : devQ;
  int err_count = 0;
  int cmp_count = 0;
  int tmo = 0;
  fth_host_ctrl dut (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
    .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn));
  fth_flash_model flashDev (.ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN), .addr(flashAddr),
    .dqIn(flashDqOut), .vppLow(vppLow), .dqOut(devQ));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    tmo++;
    if (tmo == 60000)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      results();
    end
  end
  // ==========================================
  // Bus tasks
  task automatic avXfer(input logic [2:0] a, input logic rd, input logic [31:0] wd, output logic [31:0] rv);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= wd;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chkReg(input logic [2:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] v;
    avXfer(a, 1'b1, 32'h0000_0000, v);
    `FTH_CHK(v & mask, exp)
  endtask
  task automatic doOp(input logic [3:0] op, input logic [2:0] flags);
    logic [31:0] s;
    avXfer(A_CTRL, 1'b0, {25'h000_0000, flags, op}, s);
    avXfer(A_STAT, 1'b1, 32'h0000_0000, s);
    `FTH_CHK(s[0], 1'b1)
    while (s[0] === 1'b1)
      avXfer(A_STAT, 1'b1, 32'h0000_0000, s);
  endtask
  task automatic readArr(input logic [17:0] a, input logic [7:0] exp);
    avXfer(A_ADDR, 1'b0, {14'h0000, a}, r);
    doOp(`FTH_OP_READ, 3'b000);
    chkReg(A_RDAT, 32'h0000_00FF, {24'h00_0000, exp});
  endtask
  // ==========================================
  // Test sequence
  initial
  begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    vppLow = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    chkReg(A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    chkReg(A_STAT, 32'hFFFF_FFFF, 32'h0000_0020);
    avXfer(3'h5, 1'b0, 32'h1234_5678, r);
    chkReg(3'h5, 32'hFFFF_FFFF, 32'h0000_0000);
    avXfer(A_ADDR, 1'b0, 32'h0000_0101, r);
    avXfer(A_DATA, 1'b0, 32'h0000_A55A, r);
    chkReg(A_ADDR, 32'hFFFF_FFFF, 32'h0000_0101);
    doOp(`FTH_OP_TWO_BYTE, 3'b001);
    chkReg(A_STAT, 32'h0000_FFFF, 32'h0000_B00C);
    avXfer(A_CTRL, 1'b0, {28'h000_0000, `FTH_OP_ERASE_ALL}, r);
    chkReg(A_STAT, 32'h0000_00FF, 32'h0000_000E);
    doOp(`FTH_OP_CLEAR, 3'b000);
    chkReg(A_STAT, 32'h0000_00FF, 32'h0000_0000);
    doOp(`FTH_OP_RECOVER, 3'b100);
    `FTH_CHK(flashDev.unlocked, 1'b1)
    doOp(`FTH_OP_TWO_BYTE, 3'b001);
    chkReg(A_STAT, 32'h0000_00FF, 32'h0000_0000);
    avXfer(A_ADDR, 1'b0, 32'h0000_0200, r);
    avXfer(A_DATA, 1'b0, 32'h0000_1234, r);
    doOp(`FTH_OP_TWO_BYTE, 3'b000);
    doOp(`FTH_OP_CHECK, 3'b000);
    chkReg(A_STAT, 32'h0000_00FF, 32'h0000_0000);
    readArr(18'h0_0100, 8'h5A);
    readArr(18'h0_0101, 8'hA5);
    readArr(18'h0_0200, 8'h34);
    readArr(18'h0_0201, 8'h12);
    chkReg(A_STAT, 32'h0000_00FF, 32'h0000_0020);
    vppLow <= 1'b1;
    doOp(`FTH_OP_ERASE_ALL, 3'b001);
    chkReg(A_STAT, 32'h0000_00FF, 32'h0000_0018);
    vppLow <= 1'b0;
    doOp(`FTH_OP_RECOVER, 3'b010);
    `FTH_CHK(flashDev.unlocked, 1'b0)
    readArr(18'h0_0100, 8'hFF);
    avXfer(A_ADDR, 1'b0, 32'h0000_0300, r);
    avXfer(A_DATA, 1'b0, 32'h0000_0000, r);
    doOp(`FTH_OP_ERASE_ALL, 3'b001);
    chkReg(A_STAT, 32'h0000_00FF, 32'h0000_0000);
    doOp(`FTH_OP_FINISH, 3'b000);
    chkReg(A_STAT, 32'h0000_00FF, 32'h0000_0020);
    results();
  end
endmodule // fth_host_ctrl_tb
